// ---- rtl/shmac_pkg.sv ----
// Operation codes, reset values and decode helpers of the signed halfword
// multiply-accumulate unit.
// Assumes the decode stage maps each instruction onto one shmac_op_e code.
package shmac_pkg;

  // Operation codes issued by the decode stage
  typedef enum logic [4:0] {
    MAC16_LO_LO              = 5'h00,
    MAC16_LO_HI              = 5'h01,
    MAC16_HI_LO              = 5'h02,
    MAC16_HI_HI              = 5'h03,
    MAC_WORD_BY_LO_HALF      = 5'h04,
    MAC_WORD_BY_HI_HALF      = 5'h05,
    DUAL_MAC16               = 5'h06,
    DUAL_MAC16_SWAPPED       = 5'h07,
    DUAL_MSUB16              = 5'h08,
    DUAL_MSUB16_SWAPPED      = 5'h09,
    LONG_WORD_MAC            = 5'h0a,
    LONG_MAC16_LO_LO         = 5'h0b,
    LONG_MAC16_LO_HI         = 5'h0c,
    LONG_MAC16_HI_LO         = 5'h0d,
    LONG_MAC16_HI_HI         = 5'h0e,
    LONG_DUAL_MAC16          = 5'h0f,
    LONG_DUAL_MAC16_SWAPPED  = 5'h10,
    LONG_DUAL_MSUB16         = 5'h11,
    LONG_DUAL_MSUB16_SWAPPED = 5'h12
  } shmac_op_e;

  // Operand widths and halfword field positions
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 16;
  localparam int unsigned WIDE_W = 50;
  localparam int unsigned LONG_W = 64;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Result stage state
  typedef struct packed {
    logic        res_wr;
    logic [31:0] result;
    logic        acc_wr;
    logic [31:0] acc_lo;
    logic [31:0] acc_hi;
    logic        q_set;
  } shmac_state_s;

  // Writes the 64-bit accumulator pair
  function automatic logic shmac_is_long(input shmac_op_e op);
    shmac_is_long = (op >= LONG_WORD_MAC) && (op <= LONG_DUAL_MSUB16_SWAPPED);
  endfunction : shmac_is_long

  // Two halfword products combined
  function automatic logic shmac_is_dual(input shmac_op_e op);
    shmac_is_dual = ((op >= DUAL_MAC16) && (op <= DUAL_MSUB16_SWAPPED)) ||
                    (op >= LONG_DUAL_MAC16 &&
                     op <= LONG_DUAL_MSUB16_SWAPPED);
  endfunction : shmac_is_dual

  // Crossed halfword pairing
  function automatic logic shmac_is_swap(input shmac_op_e op);
    shmac_is_swap = (op == DUAL_MAC16_SWAPPED) ||
                    (op == DUAL_MSUB16_SWAPPED) ||
                    (op == LONG_DUAL_MAC16_SWAPPED) ||
                    (op == LONG_DUAL_MSUB16_SWAPPED);
  endfunction : shmac_is_swap

  // Difference of products instead of sum
  function automatic logic shmac_is_sub(input shmac_op_e op);
    shmac_is_sub = (op == DUAL_MSUB16) || (op == DUAL_MSUB16_SWAPPED) ||
                   (op == LONG_DUAL_MSUB16) ||
                   (op == LONG_DUAL_MSUB16_SWAPPED);
  endfunction : shmac_is_sub

endpackage : shmac_pkg

// ---- rtl/shmac_mul16.sv ----
// Signed 16 x 16 multiplier with halfword selection on both operands.
// Assumes full 32-bit operand words; only the chosen halves are looked at.
`timescale 1ns/1ps
module shmac_mul16
  import shmac_pkg::*;
(
  input  wire logic [shmac_pkg::WORD_W-1:0]        word_a,
  input  wire logic [shmac_pkg::WORD_W-1:0]        word_b,
  input  wire logic                                a_hi,
  input  wire logic                                b_hi,
  output logic signed [shmac_pkg::WORD_W-1:0]      product
);
  import shmac_pkg::*;

  logic signed [HALF_W-1:0] half_a;
  logic signed [HALF_W-1:0] half_b;

  // Pick one halfword of each word and multiply them
  always_comb
  begin
    half_a  = a_hi ? word_a[HI_LSB +: HALF_W] : word_a[LO_LSB +: HALF_W];
    half_b  = b_hi ? word_b[HI_LSB +: HALF_W] : word_b[LO_LSB +: HALF_W];
    product = 32'(half_a) * 32'(half_b);  // Other halves unused
  end

endmodule : shmac_mul16

// ---- rtl/shmac_fit32.sv ----
// Reduces an exact signed sum to 32 bits and flags loss of range.
// Assumes the sum is exact in the wide input.
`timescale 1ns/1ps
module shmac_fit32
  import shmac_pkg::*;
(
  input  wire logic signed [shmac_pkg::WIDE_W-1:0] wide,
  output logic        [shmac_pkg::WORD_W-1:0]      low,
  output logic                                     ovf
);
  import shmac_pkg::*;

  // Overflow when the upper bits are not copies of bit 31
  always_comb
  begin
    low = wide[WORD_W-1:0];
    ovf = (wide != WIDE_W'($signed(wide[WORD_W-1:0])));
  end

endmodule : shmac_fit32

// ---- rtl/shmac_unit.sv ----
// Signed halfword and word-by-halfword multiply-accumulate datapath.
// Assumes the decode stage presents operands with issue_valid for one
// cycle and writes back results one cycle later; it also holds the
// sticky overflow flag and only ORs q_set into it.
//
// Operation
// - Halfword pair product plus addend
// - Unselected halfwords ignored
// - Word times half, top 32 plus addend
// - Word-by-half accumulate overflow sets sticky
// - High variant bits 31:16, low 15:0
// - Dual: straight or crossed pairs, add addend
// - Dual 32-bit sum written, overflow flagged
// - 32x32 product added to 64-bit pair
// - Halfword product sign-extended into 64 bits
// - First letter multiplicand, second multiplier
// - Long dual products into 64-bit pair
// - Low word bits 31:0, high 63:32
// - Long forms leave flags unchanged
// - Subtract forms: accumulate source, swap option
// - Failed predicate changes nothing
// - Low product minus high, plus accumulate
// - 32-bit subtract form flags accumulate overflow
`timescale 1ns/1ps
module shmac_unit
  import shmac_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         issue_valid,
  input  wire logic                         cond_pass,
  input  wire shmac_pkg::shmac_op_e         op,
  input  wire logic [shmac_pkg::WORD_W-1:0] multiplicand_register,
  input  wire logic [shmac_pkg::WORD_W-1:0] multiplier_register,
  input  wire logic [shmac_pkg::WORD_W-1:0] addend_register,
  input  wire logic [shmac_pkg::WORD_W-1:0] low_accumulator_word_in,
  input  wire logic [shmac_pkg::WORD_W-1:0] high_accumulator_word_in,
  output logic                              result_wr,
  output logic [shmac_pkg::WORD_W-1:0]      result_register,
  output logic                              acc_wr,
  output logic [shmac_pkg::WORD_W-1:0]      low_accumulator_word,
  output logic [shmac_pkg::WORD_W-1:0]      high_accumulator_word,
  output logic                              overflow_sticky_set
);
  import shmac_pkg::*;

  shmac_state_s             st;
  shmac_state_s             next_st;
  logic                     go;
  logic                     long_op;
  logic                     dual_op;
  logic                     swap_op;
  logic                     sub_op;
  logic                     a_hi0;
  logic                     b_hi0;
  logic signed [31:0]       prod0;
  logic signed [31:0]       prod1;
  logic signed [15:0]       word_half;
  logic signed [47:0]       word_prod;
  logic signed [63:0]       full_prod;
  logic signed [33:0]       dual_sum;
  logic signed [49:0]       wide_sum;
  logic signed [63:0]       acc_in;
  logic signed [63:0]       long_sum;
  logic [31:0]              fit_low;
  logic                     fit_ovf;

  // Operation class and qualified issue
  always_comb
  begin
    go      = issue_valid && cond_pass;
    long_op = shmac_is_long(op);
    dual_op = shmac_is_dual(op);
    swap_op = shmac_is_swap(op);
    sub_op  = shmac_is_sub(op);
  end

  // Halfword choice of the first multiplier; second is used by duals only
  always_comb
  begin
    a_hi0 = 1'b0;
    b_hi0 = swap_op;
    case (op)
      MAC16_LO_HI, LONG_MAC16_LO_HI:
      begin
        b_hi0 = 1'b1;
      end
      MAC16_HI_LO, LONG_MAC16_HI_LO:
      begin
        a_hi0 = 1'b1;
      end
      MAC16_HI_HI, LONG_MAC16_HI_HI:
      begin
        a_hi0 = 1'b1;
        b_hi0 = 1'b1;
      end
      default:
      begin
        a_hi0 = 1'b0;
        b_hi0 = swap_op;
      end
    endcase
  end

  // Low-half (or selected-half) product
  shmac_mul16 u_mul_lo (
    .word_a  (multiplicand_register),
    .word_b  (multiplier_register),
    .a_hi    (a_hi0),
    .b_hi    (b_hi0),
    .product (prod0)
  );

  // High-half product of the dual forms, crossed when swapped
  shmac_mul16 u_mul_hi (
    .word_a  (multiplicand_register),
    .word_b  (multiplier_register),
    .a_hi    (1'b1),
    .b_hi    (!swap_op),
    .product (prod1)
  );

  // Word-by-halfword and full word products, dual combination
  always_comb
  begin
    word_half = (op == MAC_WORD_BY_HI_HALF) ?
                multiplier_register[HI_LSB +: HALF_W] :
                multiplier_register[LO_LSB +: HALF_W];
    word_prod = 48'($signed(multiplicand_register)) *
                48'(word_half);
    full_prod = 64'($signed(multiplicand_register)) *
                64'($signed(multiplier_register));
    dual_sum  = sub_op ? (34'(prod0) - 34'(prod1)) :
                         (34'(prod0) + 34'(prod1));
  end

  // Exact 32-bit accumulate; only this add can overflow
  always_comb
  begin
    if (dual_op)
      wide_sum = 50'(dual_sum) + 50'($signed(addend_register));
    else if ((op == MAC_WORD_BY_LO_HALF) || (op == MAC_WORD_BY_HI_HALF))
      wide_sum = 50'($signed(word_prod[47:16])) +
                 50'($signed(addend_register));
    else
      wide_sum = 50'(prod0) + 50'($signed(addend_register));
  end

  // Range check of the 32-bit accumulate
  shmac_fit32 u_fit (
    .wide (wide_sum),
    .low  (fit_low),
    .ovf  (fit_ovf)
  );

  // 64-bit accumulate, low word in bits 31:0
  always_comb
  begin
    acc_in = $signed({high_accumulator_word_in,
                      low_accumulator_word_in});
    if (op == LONG_WORD_MAC)
      long_sum = acc_in + full_prod;
    else if (dual_op)
      long_sum = acc_in + 64'(dual_sum);
    else
      long_sum = acc_in + 64'(prod0);
  end

  // Next result stage; writes and flag pulse only on a passed issue
  always_comb
  begin
    next_st        = st;
    next_st.res_wr = 1'b0;
    next_st.acc_wr = 1'b0;
    next_st.q_set  = 1'b0;
    if (go && long_op)
    begin
      next_st.acc_wr = 1'b1;
      next_st.acc_lo = long_sum[31:0];
      next_st.acc_hi = long_sum[63:32];
    end
    else if (go)
    begin
      next_st.res_wr = 1'b1;
      next_st.result = fit_low;
      next_st.q_set  = fit_ovf;
    end
  end

  // Result stage register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{res_wr: 1'b0, result: RST_WORD, acc_wr: 1'b0,
              acc_lo: RST_WORD, acc_hi: RST_WORD, q_set: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the result stage
  always_comb
  begin
    result_wr             = st.res_wr;
    result_register       = st.result;
    acc_wr                = st.acc_wr;
    low_accumulator_word  = st.acc_lo;
    high_accumulator_word = st.acc_hi;
    overflow_sticky_set   = st.q_set;  // Set pulse only
  end

  // Reference values that the checks below compare with
  logic signed [31:0] chk_hh;
  logic signed [31:0] chk_lh;
  logic signed [31:0] chk_wt;
  logic signed [31:0] chk_dx;
  logic signed [31:0] chk_ds;
  logic signed [63:0] chk_lw;
  logic signed [63:0] chk_lhl;
  logic signed [47:0] chk_wp;
  logic signed [31:0] chk_p1;
  logic signed [31:0] chk_p2;

  always_comb
  begin
    chk_hh  = 32'($signed(multiplicand_register[31:16])) *
              32'($signed(multiplier_register[31:16]));
    chk_lh  = 32'($signed(multiplicand_register[15:0])) *
              32'($signed(multiplier_register[31:16]));
    chk_wp  = 48'($signed(multiplicand_register)) *
              48'($signed(multiplier_register[31:16]));
    chk_wt  = $signed(chk_wp[47:16]) + $signed(addend_register);
    chk_p1  = 32'($signed(multiplicand_register[15:0])) *
              32'($signed(multiplier_register[15:0]));
    chk_p2  = 32'($signed(multiplicand_register[31:16])) *
              32'($signed(multiplier_register[15:0]));
    chk_dx  = chk_lh + chk_p2 + $signed(addend_register);
    chk_ds  = chk_p1 - chk_hh + $signed(addend_register);
    chk_lw  = $signed({high_accumulator_word_in, low_accumulator_word_in}) +
              64'($signed(multiplicand_register)) *
              64'($signed(multiplier_register));
    chk_lhl = $signed({high_accumulator_word_in, low_accumulator_word_in}) +
              64'(chk_p2);
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_go_long;
    go && long_op;
  endsequence

  sequence s_go_short;
    go && !long_op;
  endsequence

  sequence s_skip;
    issue_valid && !cond_pass;
  endsequence

  a_skip_no_write: assert property (
    s_skip |=> !result_wr && !acc_wr && !overflow_sticky_set)
    else $error("Write after failed predicate");

  a_hh_product: assert property (
    go && op == MAC16_HI_HI |=>
      result_register == 32'($past(chk_hh) + $past($signed(addend_register))))
    else $error("Halfword high-high result wrong");

  a_word_hi_half: assert property (
    go && op == MAC_WORD_BY_HI_HALF |=>
      result_wr && result_register == $past(chk_wt))
    else $error("Word by high half result wrong");

  a_word_overflow: assert property (
    go && op == MAC_WORD_BY_HI_HALF &&
    (50'($signed(chk_wp[47:16])) + 50'($signed(addend_register))) !=
    50'(chk_wt) |=> overflow_sticky_set)
    else $error("Word by half overflow not flagged");

  a_dual_swapped: assert property (
    go && op == DUAL_MAC16_SWAPPED |=> result_register == $past(chk_dx))
    else $error("Swapped dual result wrong");

  a_dual_sub: assert property (
    go && op == DUAL_MSUB16 |=> result_register == $past(chk_ds))
    else $error("Dual subtract result wrong");

  a_long_word: assert property (
    go && op == LONG_WORD_MAC |=>
      acc_wr && {high_accumulator_word, low_accumulator_word} ==
      $past(chk_lw))
    else $error("Long word accumulate wrong");

  a_long_half: assert property (
    go && op == LONG_MAC16_HI_LO |=>
      low_accumulator_word == $past(chk_lhl[31:0]) &&
      high_accumulator_word == $past(chk_lhl[63:32]))
    else $error("Long halfword accumulate wrong");

  a_long_no_flag: assert property (
    s_go_long |=> acc_wr && !overflow_sticky_set && !result_wr)
    else $error("Long form touched flags");

  a_flag_source: assert property (
    overflow_sticky_set |-> $past(go) && !$past(long_op) && result_wr)
    else $error("Overflow without a 32-bit accumulate");

  a_short_write: assert property (
    s_go_short |=> result_wr && !acc_wr)
    else $error("32-bit form did not write its result");

endmodule : shmac_unit

// ---- verif/shmac_partner.sv ----
// Far-side model: the status holder that keeps the sticky overflow flag.
// Assumes the unit only pulses a set request for one cycle.
`timescale 1ns/1ps
module shmac_partner (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic overflow_sticky_set,
  output logic      sticky
);
  // Flag is only ever set here; only reset clears it in this model
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sticky <= 1'b0;
    else if (overflow_sticky_set)
      sticky <= 1'b1;
  end
endmodule : shmac_partner

// ---- verif/shmac_unit_test.sv ----
// Self-checking bench of the multiply-accumulate unit.
// Assumes results appear one cycle after an accepted issue.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); \
  end end
module shmac_unit_test;
  import shmac_pkg::*;
  logic        mclk, rstn, issue_valid, cond_pass, sticky;
  shmac_op_e   op;
  logic [31:0] mcand, mplier, addend, acc_lo_in, acc_hi_in;
  logic        result_wr, acc_wr, ovf_set;
  logic [31:0] result_register, acc_lo, acc_hi;
  logic        e_rwr, e_awr, e_ovf, e_sticky;
  logic [31:0] e_res;
  logic [63:0] e_acc;
  logic [64:0] r;
  int          n_errors, samples_checked, cycles;
  logic [31:0] sets [3][5] = '{
    '{32'h1234_fedc, 32'h8001_7fff, 32'h0000_1000, 32'hffff_fff0, 32'h1},
    '{32'h8000_8000, 32'h8000_8000, 32'h7fff_ffff, 32'hffff_ffff,
      32'h7fff_ffff},
    '{32'h7fff_8000, 32'h8000_7fff, 32'h8000_0000, 32'h0, 32'h8000_0000}};

  shmac_unit i_dut (
    .mclk(mclk), .rstn(rstn), .issue_valid(issue_valid),
    .cond_pass(cond_pass), .op(op), .multiplicand_register(mcand),
    .multiplier_register(mplier), .addend_register(addend),
    .low_accumulator_word_in(acc_lo_in),
    .high_accumulator_word_in(acc_hi_in), .result_wr(result_wr),
    .result_register(result_register), .acc_wr(acc_wr),
    .low_accumulator_word(acc_lo), .high_accumulator_word(acc_hi),
    .overflow_sticky_set(ovf_set));
  shmac_partner i_partner (
    .mclk(mclk), .rstn(rstn), .overflow_sticky_set(ovf_set),
    .sticky(sticky));

  // Reference arithmetic: returns overflow bit above the 64-bit sum
  function automatic logic [64:0] model(input shmac_op_e o,
    input logic [31:0] a, b, c, lo, hi);
    longint al, ah, bl, bh, x0, x1, s, acc, sc;
    logic   [4:0] k;
    logic   swp, sub;
    al = longint'($signed(a[15:0]));
    ah = longint'($signed(a[31:16]));
    bl = longint'($signed(b[15:0]));
    bh = longint'($signed(b[31:16]));
    sc = longint'($signed(c));
    acc = {hi, lo};
    k = o;
    swp = o inside {DUAL_MAC16_SWAPPED, DUAL_MSUB16_SWAPPED,
                    LONG_DUAL_MAC16_SWAPPED, LONG_DUAL_MSUB16_SWAPPED};
    sub = o inside {DUAL_MSUB16, DUAL_MSUB16_SWAPPED, LONG_DUAL_MSUB16,
                    LONG_DUAL_MSUB16_SWAPPED};
    if (o <= MAC16_HI_HI)
      s = (k[1] ? ah : al) * (k[0] ? bh : bl) + sc;
    else if (o <= MAC_WORD_BY_HI_HALF)
      s = ((longint'($signed(a)) * (k[0] ? bh : bl)) >>> 16) + sc;
    else if (o == LONG_WORD_MAC)
      s = longint'($signed(a)) * longint'($signed(b)) + acc;
    else if (o >= LONG_MAC16_LO_LO && o <= LONG_MAC16_HI_HI)
    begin
      k = k - 5'h0b;
      s = (k[1] ? ah : al) * (k[0] ? bh : bl) + acc;
    end
    else
    begin
      x0 = swp ? al * bh : al * bl;
      x1 = swp ? ah * bl : ah * bh;
      s = (sub ? x0 - x1 : x0 + x1) + ((o >= LONG_DUAL_MAC16) ? acc : sc);
    end
    model = {s != longint'($signed(s[31:0])), s};
  endfunction : model

  // Clock at 100 ns period
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Compare each cycle, then predict the next cycle
  always @(negedge mclk)
  begin
    if (!rstn)
    begin
      `CHK(result_register, RST_WORD)
      {e_rwr, e_awr, e_ovf, e_sticky, e_res, e_acc} = '0;
    end
    else
    begin
      `CHK(result_wr, e_rwr)
      `CHK(acc_wr, e_awr)
      `CHK(result_register, e_res)
      `CHK(acc_lo, e_acc[31:0])
      `CHK(acc_hi, e_acc[63:32])
      `CHK(ovf_set, e_ovf)
      `CHK(sticky, e_sticky)
      e_sticky = e_sticky | e_ovf;
      {e_rwr, e_awr, e_ovf} = '0;
      if (issue_valid && cond_pass)
      begin
        r = model(op, mcand, mplier, addend, acc_lo_in, acc_hi_in);
        if (op >= LONG_WORD_MAC)
          {e_awr, e_acc} = {1'b1, r[63:0]};
        else
          {e_rwr, e_res, e_ovf} = {1'b1, r[31:0], r[64]};
      end
    end
  end

  // Operands come from separate bench ports; accumulator words are distinct
  task automatic issue(input shmac_op_e o, input logic cp, input int s);
    @(posedge mclk);
    issue_valid <= 1'b1;
    cond_pass <= cp;
    op <= o;
    {mcand, mplier, addend, acc_lo_in, acc_hi_in} <=
      {sets[s][0], sets[s][1], sets[s][2], sets[s][3], sets[s][4]};
  endtask : issue

  task automatic idle(input int n);
    repeat (n) @(posedge mclk) issue_valid <= 1'b0;
  endtask : idle

  task automatic stop_test;
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Cut a hang short
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // Test sequence
  initial
  begin
    {rstn, issue_valid, cond_pass} = 3'b000;
    op = MAC16_LO_LO;
    {mcand, mplier, addend, acc_lo_in, acc_hi_in} = '0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    for (int s = 0; s < 3; s++)
      for (int i = 0; i < 19; i++)
        issue(shmac_op_e'(i), 1'b1, s);
    idle(2);
    $display("Test all operations back to back done");
    for (int i = 0; i < 19; i++)
    begin
      issue(shmac_op_e'(i), 1'b0, 1);
      issue(shmac_op_e'(18 - i), 1'b1, 0);
    end
    idle(2);
    $display("Test failed predicate done");
    @(posedge mclk) rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    issue(DUAL_MSUB16, 1'b1, 2);
    issue(LONG_DUAL_MSUB16_SWAPPED, 1'b1, 2);
    idle(3);
    $display("Test reset in mid run done");
    stop_test();
  end
endmodule : shmac_unit_test
